// ### core/lopr_alarm_irq.sv
// Purpose: alarm status, change capture and interrupt pin
// Assumes: detect already synchronised
// Notes: a change in the clearing cycle survives the clear
`default_nettype none
module lopr_alarm_irq (
   input wire logic sys_clk,
   input wire logic nrst,
   lopr_alarm_if.irq a
);
   logic [7:0] status_q;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic irq_n_q;
   wire [7:0] change = a.detect ^ status_q;
   wire [7:0] set = change & a.enable;

   // set wins over the read clear so no edge is lost
   assign flags_d = a.soft_rst ? lopr_pkg::RST_BYTE : ((a.clr ? 8'h00 : flags_q) | set);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= lopr_pkg::RST_BYTE;
         flags_q <= lopr_pkg::RST_BYTE;
         irq_n_q <= 1'b1;
      end else begin
         status_q <= a.detect;
         flags_q <= flags_d;
         irq_n_q <= ~(|flags_d);
      end
   end

   assign a.status = status_q;
   assign a.flags = flags_q;
   assign a.irq_n = irq_n_q;

   property p_masked;
      @(posedge sys_clk) disable iff (!nrst)
      1'b1 |=> ((flags_q & ~$past(flags_q)) & ~$past(a.enable)) == 8'h00;
   endproperty
   a_masked: assert property (p_masked) else $error("flag set on masked channel");
   property p_change_sets;
      @(posedge sys_clk) disable iff (!nrst)
      !a.soft_rst |=> (flags_q & $past(set)) == $past(set);
   endproperty
   a_change_sets: assert property (p_change_sets) else $error("change did not set flag");
   property p_hold;
      @(posedge sys_clk) disable iff (!nrst)
      !a.clr && !a.soft_rst |=> (flags_q & $past(flags_q)) == $past(flags_q);
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost without clear");
   property p_pin;
      @(posedge sys_clk) disable iff (!nrst)
      irq_n_q == (flags_q == 8'h00);
   endproperty
   a_pin: assert property (p_pin) else $error("interrupt pin disagrees with flags");
endmodule
`default_nettype wire

// ### core/lopr_if.sv
// Purpose: carriers between the register top and its sample memory and alarm logic
// Assumes: all signals on sys_clk
// Notes: none
`default_nettype none
interface lopr_mem_if;
   logic [7:0] wr_mask;
   logic [4:0] addr;
   logic [6:0] wdata;
   logic [2:0] rd_chan;
   logic [6:0] rdata;
   logic [4:0] tx_phase;
   logic [7:0][6:0] tx_samples;
   modport ctrl (output wr_mask, addr, wdata, rd_chan, tx_phase, input rdata, tx_samples);
   modport mem (input wr_mask, addr, wdata, rd_chan, tx_phase, output rdata, tx_samples);
endinterface

interface lopr_alarm_if;
   logic clr;
   logic soft_rst;
   logic [7:0] enable;
   logic [7:0] detect;
   logic [7:0] status;
   logic [7:0] flags;
   logic irq_n;
   modport ctrl (output clr, soft_rst, enable, detect, input status, flags, irq_n);
   modport irq (input clr, soft_rst, enable, detect, output status, flags, irq_n);
endinterface
`default_nettype wire

// ### core/lopr_pkg.sv
// Purpose: shared constants, register map and helpers of the line output / alarm / pulse regs
// Assumes: 8-bit host data, eight channels, one clock
// Notes: all offsets are byte addresses on the host port
`default_nettype none
package lopr_pkg;
   localparam int NCH = 8;
   localparam int SAMP_W = 7;
   localparam int LOC_W = 5;
   localparam int NLOC = 32;
   localparam int CH_W = 3;
   localparam int REG_W = 8;
   // =====================================
   // register map
   localparam logic [7:0] ADDR_TX_DIS = 8'h12;
   localparam logic [7:0] ADDR_ALARM_STAT = 8'h13;
   localparam logic [7:0] ADDR_ALARM_EN = 8'h14;
   localparam logic [7:0] ADDR_ALARM_CHG = 8'h15;
   localparam logic [7:0] ADDR_BCAST = 8'h16;
   localparam logic [7:0] ADDR_SADDR = 8'h17;
   localparam logic [7:0] ADDR_SDATA = 8'h18;
   localparam logic [7:0] ADDR_SRC = 8'h19;
   // =====================================
   // fields and reset values
   localparam int CH_LSB = 5;
   localparam int LOC_MSB = 4;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [6:0] RST_SAMPLE = 7'h00;
   localparam logic [1:0] SETTLE_CYC = 2'h3;
   // =====================================
   // pulse timing: samples per unit_interval
   localparam logic [4:0] E1_UNIT_INTERVAL_SAMPLES = 5'h0C;
   localparam logic [4:0] T1_UNIT_INTERVAL_SAMPLES = 5'h0E;
   // built-in shape levels, two's complement
   localparam logic [6:0] ROM_PEAK = 7'h30;
   localparam logic [6:0] ROM_TAIL = 7'h7C;
   localparam logic [6:0] SAMP_MAX_POS = 7'h3F;
   localparam logic [6:0] SAMP_MAX_NEG = 7'h40;

   function automatic logic [6:0] rom_sample(input logic e1, input logic [4:0] ph);
      logic [4:0] span;
      span = e1 ? E1_UNIT_INTERVAL_SAMPLES : T1_UNIT_INTERVAL_SAMPLES;
      if (ph < span) begin
         rom_sample = ROM_PEAK;
      end else if (!e1 && ph < 5'(span + span)) begin
         rom_sample = ROM_TAIL;
      end else begin
         rom_sample = RST_SAMPLE;
      end
   endfunction

   function automatic logic second_unit_interval(input logic e1, input logic [4:0] ph);
      second_unit_interval = e1 && (ph >= E1_UNIT_INTERVAL_SAMPLES);
   endfunction
endpackage
`default_nettype wire

// ### core/lopr_regs.sv
// Purpose: host register group for driver disable, alarm status/interrupt and custom pulses
// Assumes: host strobes and soft_rst are one-cycle pulses on sys_clk
// Notes: alarm_indication_signal is asynchronous and synchronised here
`default_nettype none
module lopr_regs (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic soft_rst,
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   input wire logic [7:0] alarm_indication_signal,
   input wire logic [7:0] e1_mode,
   input wire logic [4:0] tx_phase,
   output logic [7:0] tx_hiz,
   output logic [7:0] pulse_src_custom,
   output logic [55:0] tx_samples,
   output logic int_n
);
   // ======================================
   // storage
   logic [7:0] tx_dis_q;
   logic [7:0] irq_en_q;
   logic [7:0] bmask_q;
   logic [7:0] saddr_q;
   logic [6:0] sdata_q;
   logic [7:0] src_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [55:0] samples_q;
   logic [1:0] settle_q;

   lopr_mem_if mi ();
   lopr_alarm_if ai ();

   // ======================================
   // address decode
   wire wr_tx_dis = host_wr && host_addr == lopr_pkg::ADDR_TX_DIS;
   wire wr_en = host_wr && host_addr == lopr_pkg::ADDR_ALARM_EN;
   wire wr_bmask = host_wr && host_addr == lopr_pkg::ADDR_BCAST;
   wire wr_saddr = host_wr && host_addr == lopr_pkg::ADDR_SADDR;
   wire wr_sdata = host_wr && host_addr == lopr_pkg::ADDR_SDATA;
   wire wr_src = host_wr && host_addr == lopr_pkg::ADDR_SRC;
   wire rd_chg = host_rd && host_addr == lopr_pkg::ADDR_ALARM_CHG;
   wire [2:0] tgt_chan = saddr_q[7:lopr_pkg::CH_LSB];
   wire [4:0] tgt_loc = saddr_q[lopr_pkg::LOC_MSB:0];
   wire [7:0] tgt_onehot = 8'h01 << tgt_chan;
   // a zero mask falls back to the addressed channel alone
   wire [7:0] chan_mask = (bmask_q != 8'h00) ? bmask_q : tgt_onehot;

   // ======================================
   // read mux, unmapped offsets read zero
   logic [7:0] rd_mux;
   always_comb begin
      case (host_addr)
         lopr_pkg::ADDR_TX_DIS: rd_mux = tx_dis_q;
         lopr_pkg::ADDR_ALARM_STAT: rd_mux = ai.status;
         lopr_pkg::ADDR_ALARM_EN: rd_mux = irq_en_q;
         lopr_pkg::ADDR_ALARM_CHG: rd_mux = ai.flags;
         lopr_pkg::ADDR_BCAST: rd_mux = bmask_q;
         lopr_pkg::ADDR_SADDR: rd_mux = saddr_q;
         lopr_pkg::ADDR_SDATA: rd_mux = {1'b0, mi.rdata};
         lopr_pkg::ADDR_SRC: rd_mux = src_q;
         default: rd_mux = lopr_pkg::RST_BYTE;
      endcase
   end

   // ======================================
   // control registers, cleared by reset or soft reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tx_dis_q <= lopr_pkg::RST_BYTE;
         irq_en_q <= lopr_pkg::RST_BYTE;
         bmask_q <= lopr_pkg::RST_BYTE;
         saddr_q <= lopr_pkg::RST_BYTE;
         src_q <= lopr_pkg::RST_BYTE;
      end else if (soft_rst) begin
         tx_dis_q <= lopr_pkg::RST_BYTE;
         irq_en_q <= lopr_pkg::RST_BYTE;
         bmask_q <= lopr_pkg::RST_BYTE;
         saddr_q <= lopr_pkg::RST_BYTE;
         src_q <= lopr_pkg::RST_BYTE;
      end else begin
         if (wr_tx_dis) tx_dis_q <= host_wdata;
         if (wr_en) irq_en_q <= host_wdata;
         if (wr_bmask) bmask_q <= host_wdata;
         if (wr_saddr) saddr_q <= host_wdata;
         if (wr_src) src_q <= host_wdata;
      end
   end

   // soft reset leaves the sample data alone
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sdata_q <= lopr_pkg::RST_SAMPLE;
      end else if (wr_sdata) begin
         sdata_q <= host_wdata[6:0];
      end
   end

   // ======================================
   // host read answer, one cycle after the strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= lopr_pkg::RST_BYTE;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= host_rd ? rd_mux : rdata_q;
         rvalid_q <= host_rd;
      end
   end

   // ======================================
   // alarm input synchroniser
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= lopr_pkg::RST_BYTE;
         sync2_q <= lopr_pkg::RST_BYTE;
         settle_q <= 2'h0;
      end else begin
         sync1_q <= alarm_indication_signal;
         sync2_q <= sync1_q;
         settle_q <= (settle_q == lopr_pkg::SETTLE_CYC) ? settle_q : 2'(settle_q + 2'h1);
      end
   end

   assign ai.clr = rd_chg;
   assign ai.soft_rst = soft_rst;
   assign ai.enable = irq_en_q;
   assign ai.detect = sync2_q;

   lopr_alarm_irq u_alarm (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .a(ai.irq)
   );

   // ======================================
   // sample memory and transmit shape selection
   assign mi.wr_mask = wr_sdata ? chan_mask : 8'h00;
   assign mi.addr = tgt_loc;
   assign mi.wdata = host_wdata[6:0];
   assign mi.rd_chan = tgt_chan;
   assign mi.tx_phase = tx_phase;

   lopr_sample_mem u_mem (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .m(mi.mem)
   );

   logic [55:0] samples_d;
   for (genvar c = 0; c < lopr_pkg::NCH; c++) begin : g_shape
      // second unit_interval custom samples in E1 are forced to zero, whatever the host wrote
      wire ign = lopr_pkg::second_unit_interval(e1_mode[c], tx_phase);
      wire [6:0] custom = ign ? lopr_pkg::RST_SAMPLE : mi.tx_samples[c];
      wire [6:0] fixed = lopr_pkg::rom_sample(e1_mode[c], tx_phase);
      // seven-bit two's complement passes untouched; the DAC sign-extends
      assign samples_d[c*7 +: 7] = src_q[c] ? custom : fixed;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         samples_q <= 56'h0;
      end else begin
         samples_q <= samples_d;
      end
   end

   assign host_rdata = rdata_q;
   assign host_rvalid = rvalid_q;
   assign tx_hiz = tx_dis_q;
   assign pulse_src_custom = src_q;
   assign tx_samples = samples_q;
   assign int_n = ai.irq_n;

   // ======================================
   // checks
   property p_hiz;
      @(posedge sys_clk) disable iff (!nrst)
      wr_tx_dis && !soft_rst |=> tx_hiz == $past(host_wdata);
   endproperty
   a_hiz: assert property (p_hiz) else $error("driver disable not applied");

   property p_status;
      @(posedge sys_clk) disable iff (!nrst)
      settle_q == lopr_pkg::SETTLE_CYC |-> ai.status == $past(alarm_indication_signal, 3);
   endproperty
   a_status: assert property (p_status) else $error("alarm status not following input");

   property p_rdata;
      @(posedge sys_clk) disable iff (!nrst)
      host_rd && host_addr == lopr_pkg::ADDR_SDATA |=> host_rvalid && host_rdata == {1'b0, $past(mi.rdata)};
   endproperty
   a_rdata: assert property (p_rdata) else $error("sample read wrong");

   property p_keep;
      @(posedge sys_clk) disable iff (!nrst)
      soft_rst && !wr_sdata |=> sdata_q == $past(sdata_q);
   endproperty
   a_keep: assert property (p_keep) else $error("soft reset changed sample data");

   property p_custom;
      @(posedge sys_clk) disable iff (!nrst)
      src_q[0] && !lopr_pkg::second_unit_interval(e1_mode[0], tx_phase)
         |=> tx_samples[6:0] == $past(mi.tx_samples[0]);
   endproperty
   a_custom: assert property (p_custom) else $error("custom shape not used");

   property p_fixed;
      @(posedge sys_clk) disable iff (!nrst)
      !src_q[1] |=> tx_samples[13:7] == lopr_pkg::rom_sample($past(e1_mode[1]), $past(tx_phase));
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed shape not used");

   property p_e1_tail;
      @(posedge sys_clk) disable iff (!nrst)
      src_q[2] && e1_mode[2] && tx_phase >= lopr_pkg::E1_UNIT_INTERVAL_SAMPLES
         |=> tx_samples[20:14] == 7'h00;
   endproperty
   a_e1_tail: assert property (p_e1_tail) else $error("E1 second interval not ignored");

   property p_soft;
      @(posedge sys_clk) disable iff (!nrst)
      soft_rst |=> tx_hiz == 8'h00 && pulse_src_custom == 8'h00 && saddr_q == 8'h00;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset did not clear registers");

   // flags and the pin must also come back clean, or a stale interrupt survives
   property p_soft_alarm;
      @(posedge sys_clk) disable iff (!nrst)
      soft_rst |=> ai.flags == 8'h00 && int_n && irq_en_q == 8'h00 && bmask_q == 8'h00;
   endproperty
   a_soft_alarm: assert property (p_soft_alarm) else $error("soft reset left alarm state");

   // the read answer is a single-cycle echo of the strobe
   property p_rvalid;
      @(posedge sys_clk) disable iff (!nrst)
      1'b1 |=> host_rvalid == $past(host_rd);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("late read answer");

   property p_target;
      @(posedge sys_clk) disable iff (!nrst)
      wr_sdata && bmask_q == 8'h00 |-> mi.wr_mask == (8'h01 << saddr_q[7:lopr_pkg::CH_LSB]);
   endproperty
   a_target: assert property (p_target) else $error("sample write missed target channel");

   property p_bcast_mask;
      @(posedge sys_clk) disable iff (!nrst)
      wr_sdata && bmask_q != 8'h00 |-> mi.wr_mask == bmask_q;
   endproperty
   a_bcast_mask: assert property (p_bcast_mask) else $error("broadcast mask not applied");

   // memory must never change outside a data register write
   property p_no_stray;
      @(posedge sys_clk) disable iff (!nrst)
      !wr_sdata |-> mi.wr_mask == 8'h00;
   endproperty
   a_no_stray: assert property (p_no_stray) else $error("stray sample write");

   property p_saddr;
      @(posedge sys_clk) disable iff (!nrst)
      wr_saddr && !soft_rst |=> mi.rd_chan == $past(host_wdata[7:lopr_pkg::CH_LSB])
         && mi.addr == $past(host_wdata[lopr_pkg::LOC_MSB:0]);
   endproperty
   a_saddr: assert property (p_saddr) else $error("sample address not decoded");

   property p_irq_en;
      @(posedge sys_clk) disable iff (!nrst)
      wr_en && !soft_rst |=> irq_en_q == $past(host_wdata);
   endproperty
   a_irq_en: assert property (p_irq_en) else $error("interrupt enable not stored");

   property p_src;
      @(posedge sys_clk) disable iff (!nrst)
      wr_src && !soft_rst |=> pulse_src_custom == $past(host_wdata);
   endproperty
   a_src: assert property (p_src) else $error("source select not stored");

   // a read of the flags with no fresh change must release the pin
   property p_int_release;
      @(posedge sys_clk) disable iff (!nrst)
      rd_chg && sync2_q == ai.status |=> int_n;
   endproperty
   a_int_release: assert property (p_int_release) else $error("interrupt not released");
endmodule
`default_nettype wire

// ### core/lopr_sample_mem.sv
// Purpose: per-channel custom pulse sample memories, host port plus transmit fetch
// Assumes: write mask already resolved to channels
// Notes: cleared by power-up reset only
`default_nettype none
module lopr_sample_mem (
   input wire logic sys_clk,
   input wire logic nrst,
   lopr_mem_if.mem m
);
   logic [6:0] ram_q [lopr_pkg::NCH][lopr_pkg::NLOC];

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int c = 0; c < lopr_pkg::NCH; c++) begin
            for (int l = 0; l < lopr_pkg::NLOC; l++) begin
               ram_q[c][l] <= lopr_pkg::RST_SAMPLE;
            end
         end
      end else begin
         for (int c = 0; c < lopr_pkg::NCH; c++) begin
            if (m.wr_mask[c]) begin
               ram_q[c][m.addr] <= m.wdata;
            end
         end
      end
   end

   assign m.rdata = ram_q[m.rd_chan][m.addr];
   for (genvar c = 0; c < lopr_pkg::NCH; c++) begin : g_tx
      assign m.tx_samples[c] = ram_q[c][m.tx_phase];
   end

   property p_bcast_write;
      @(posedge sys_clk) disable iff (!nrst)
      m.wr_mask[7] |=> ram_q[7][$past(m.addr)] == $past(m.wdata);
   endproperty
   a_bcast_write: assert property (p_bcast_write) else $error("masked channel not written");
endmodule
`default_nettype wire

// ### verif/lopr_host_model.sv
// Purpose: host microprocessor model driving the register port
// Assumes: one-cycle strobes, answer one cycle after a read edge
// Notes: tasks are called from the bench by hierarchical name
`default_nettype none
module lopr_host_model (
   input wire logic sys_clk,
   output logic [7:0] host_addr,
   output logic [7:0] host_wdata,
   output logic host_wr,
   output logic host_rd,
   input wire logic [7:0] host_rdata,
   input wire logic host_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_addr = 8'h00;
      host_wdata = 8'h00;
      host_wr = 1'b0;
      host_rd = 1'b0;
   end
   // =====================================
   // bus cycles
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      host_addr = a;
      // reserved top bit of the sample data kept at zero
      host_wdata = (a == lopr_pkg::ADDR_SDATA) ? {1'b0, d[6:0]} : d;
      host_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      host_wr = 1'b0;
      // released data shows the inverse so a stale value is never mistaken
      host_wdata = ~host_wdata;
      host_addr = ~a;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge sys_clk);
      #1;
      host_addr = a;
      host_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      host_rd = 1'b0;
      ok = host_rvalid;
      d = host_rdata;
      host_addr = ~a;
   endtask
endmodule
`default_nettype wire

// ### verif/lopr_regs_tb.sv
// Purpose: self-checking bench of the register group
// Assumes: seed fixed, host never leaves the valid sample locations
// Notes: expectations come from bench functions only
`default_nettype none
module lopr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, nrst, soft_rst, host_wr, host_rd, host_rvalid, int_n, ok;
   logic [7:0] host_addr, host_wdata, host_rdata, alarm_indication_signal;
   logic [7:0] e1_mode, tx_hiz, pulse_src_custom;
   logic [7:0] v, r, en, fl, ad, m, src;
   logic [4:0] tx_phase, loc;
   logic [55:0] tx_samples;
   logic [6:0] dat [8];
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;

   lopr_regs lopr_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .soft_rst(soft_rst),
      .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .alarm_indication_signal(alarm_indication_signal),
      .e1_mode(e1_mode), .tx_phase(tx_phase), .tx_hiz(tx_hiz),
      .pulse_src_custom(pulse_src_custom), .tx_samples(tx_samples), .int_n(int_n));
   lopr_host_model lopr_host_model_inst (.sys_clk(sys_clk), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // =====================================
   // helpers
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      lopr_host_model_inst.wr_reg(a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      lopr_host_model_inst.rd_reg(a, d, ok);
      check("rvalid", {7'h00, ok}, 8'h01);
   endtask
   function automatic logic [6:0] exp_tx(input logic cus, input logic e1, input logic [4:0] ph,
      input logic [6:0] mem);
      logic [4:0] span;
      span = e1 ? 5'h0C : 5'h0E;
      if (cus) begin
         exp_tx = (e1 && ph >= 5'h0C) ? 7'h00 : mem;
      end else begin
         exp_tx = (ph < span) ? 7'h30 : ((!e1 && ph < 5'(span + span)) ? 7'h7C : 7'h00);
      end
   endfunction
   task automatic wrap_up();
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // =====================================
   // main sequence
   initial begin
      v = 8'($urandom(84491));
      nrst = 1'b0;
      soft_rst = 1'b0;
      alarm_indication_signal = 8'h00;
      e1_mode = 8'h00;
      tx_phase = 5'h00;
      repeat (6) @(posedge sys_clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge sys_clk);
      for (int a = 8'h12; a <= 8'h1A; a++) begin
         rd(8'(a), r);
         check("reset value", r, 8'h00);
      end
      v = 8'($urandom);
      wr(lopr_pkg::ADDR_TX_DIS, v);
      check("tx_hiz", tx_hiz, v);
      rd(lopr_pkg::ADDR_TX_DIS, r);
      check("tx disable readback", r, v);
      // channel 7 always masked, channel 0 always enabled
      en = (8'($urandom) | 8'h01) & 8'h7F;
      wr(lopr_pkg::ADDR_ALARM_EN, en);
      fl = 8'h00;
      ad = 8'h00;
      for (int i = 0; i < 4; i++) begin
         v = (i == 3) ? (ad ^ 8'h80) : 8'($urandom);
         fl = fl | ((v ^ ad) & en);
         ad = v;
         alarm_indication_signal = v;
         repeat (5) @(posedge sys_clk);
         #1;
         check("int_n", {7'h00, int_n}, {7'h00, fl == 8'h00});
         rd(lopr_pkg::ADDR_ALARM_STAT, r);
         check("alarm status", r, ad);
      end
      rd(lopr_pkg::ADDR_ALARM_CHG, r);
      check("change flags", r, fl);
      check("int_n released", {7'h00, int_n}, 8'h01);
      rd(lopr_pkg::ADDR_ALARM_CHG, r);
      check("flags cleared", r, 8'h00);
      // locations kept inside the E1 range of 24
      loc = 5'(12 + $urandom % 11);
      for (int c = 0; c < 8; c++) begin
         dat[c] = (c == 0) ? 7'h3F : ((c == 1) ? 7'h40 : 7'($urandom));
         wr(lopr_pkg::ADDR_SADDR, {3'(c), loc});
         wr(lopr_pkg::ADDR_SDATA, {1'b0, dat[c]});
      end
      for (int c = 0; c < 8; c++) begin
         wr(lopr_pkg::ADDR_SADDR, {3'(c), loc});
         rd(lopr_pkg::ADDR_SDATA, r);
         check("sample readback", r, {1'b0, dat[c]});
      end
      m = 8'($urandom) | 8'h01;
      v = {1'b0, 7'($urandom)};
      wr(lopr_pkg::ADDR_BCAST, m);
      wr(lopr_pkg::ADDR_SADDR, {3'h0, 5'(loc + 1)});
      wr(lopr_pkg::ADDR_SDATA, v);
      wr(lopr_pkg::ADDR_BCAST, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(lopr_pkg::ADDR_SADDR, {3'(c), 5'(loc + 1)});
         rd(lopr_pkg::ADDR_SDATA, r);
         check("broadcast sample", r, m[c] ? v : 8'h00);
      end
      for (int k = 0; k < 3; k++) begin
         src = 8'($urandom);
         e1_mode = 8'($urandom);
         wr(lopr_pkg::ADDR_SRC, src);
         check("source select", pulse_src_custom, src);
         for (int p = 0; p < 2; p++) begin
            tx_phase = (p == 0) ? loc : 5'(3 + k);
            @(posedge sys_clk);
            #1;
            for (int c = 0; c < 8; c++) begin
               check("tx sample", {1'b0, tx_samples[7*c +: 7]}, {1'b0, exp_tx(src[c],
                  e1_mode[c], tx_phase, (p == 0) ? dat[c] : 7'h00)});
            end
         end
      end
      wr(lopr_pkg::ADDR_SADDR, 8'h00);
      wr(lopr_pkg::ADDR_SDATA, 8'h55);
      wr(lopr_pkg::ADDR_SADDR, {3'h2, loc});
      wr(lopr_pkg::ADDR_BCAST, 8'h0F);
      soft_rst = 1'b1;
      @(posedge sys_clk);
      #1 soft_rst = 1'b0;
      for (int a = 8'h12; a <= 8'h19; a++) begin
         if (a != 8'h13 && a != 8'h18) begin
            rd(8'(a), r);
            check("soft reset value", r, 8'h00);
         end
      end
      rd(lopr_pkg::ADDR_ALARM_STAT, r);
      check("status after soft reset", r, ad);
      rd(lopr_pkg::ADDR_SDATA, r);
      check("data kept by soft reset", r, 8'h55);
      wrap_up();
   end
endmodule
`default_nettype wire
